/* File: rtl/pdm_consts.vh */
/*
 * constants of the power-down mode sequencer: register offsets, field positions,
 * reset values, mode codes and settling counts.
 * assumes an 8-bit register port with one-cycle strobes and a 125 MHz clock.
 */
// How it works
// - reset low in standby restarts oscillator; release starts reset handling
// - settling select 000..011 gives 8192..65536 states, 1xx gives 131072
// - halt in active or subactive with standby and watch-clock bits set: watch
// - watch keeps only timer a and optionally the display running, ports held
// - watch leaves only on timer a, request 0, wake-up pins or reset low
// - watch wake goes to high, medium or subactive by low and medium bits
// - watch wake into active waits settling time before clock and handling
// - no interrupt wake while the mask flag is set or request disabled
// - halt in subactive with standby 0, low-speed 1, watch clock 1: subsleep
// - subsleep keeps timers a, c, g and display running, ports held
// - subsleep leaves on timers a/c/g, requests 0-4, wake-up pins, or reset
// - subactive entered from watch with low-speed 1, or from subsleep wake
// - subactive halt with standby and watch clock set goes to watch; reset wins
// - subactive cpu clock is watch clock divided by 2, 4 or 8
// - medium bit 1 and low-speed 0 resume in medium-speed after wakes
// - medium halt: standby with watch clock 0 and low-speed 0 goes standby, with watch clock 1 goes watch
// - active halt with standby and low-speed bits both 0 enters sleep
// - reset low in medium-speed enters reset state and ends medium-speed
// - medium-speed cpu clock is one eighth of the high-speed clock
// - standby leaves on requests 0/1 or wake-up pins after settling wait
// - divider 00 is /8, 01 is /4, 1x is /2; locked while in subactive
`ifndef PDM_CONSTS_VH
`define PDM_CONSTS_VH

// register offsets
`define PDM_ADDR_W 2
`define PDM_OFS_CTRL_ONE 2'h0
`define PDM_OFS_CTRL_TWO 2'h1
`define PDM_OFS_TIMER_A 2'h2
`define PDM_OFS_STATUS 2'h3

// control one fields
`define PDM_BIT_STANDBY 7
`define PDM_BIT_SETTLE_HI 6
`define PDM_BIT_SETTLE_LO 4
`define PDM_BIT_LOW_SPEED 3
`define PDM_CTRL_ONE_RSV 8'h07
`define PDM_CTRL_ONE_RST 8'h07

// control two fields
`define PDM_BIT_NOISE_SEL 4
`define PDM_BIT_DIRECT 3
`define PDM_BIT_MEDIUM 2
`define PDM_BIT_SUBDIV_HI 1
`define PDM_CTRL_TWO_RSV 8'he0
`define PDM_CTRL_TWO_RST 8'he0

// timer a mode register fields
`define PDM_BIT_WATCH_CLK 3
`define PDM_BIT_LCD_WATCH 0
`define PDM_TIMER_A_RST 8'h00

// mode codes
`define PDM_MODE_W 4
`define PDM_M_ACT_HI 4'h0
`define PDM_M_ACT_MED 4'h1
`define PDM_M_SLEEP 4'h2
`define PDM_M_STANDBY 4'h3
`define PDM_M_WATCH 4'h4
`define PDM_M_SUBSLEEP 4'h5
`define PDM_M_SUBACT 4'h6
`define PDM_M_SETTLE 4'h7
`define PDM_M_RESET 4'h8

// clock source codes
`define PDM_SRC_SYS 2'h0
`define PDM_SRC_WATCH 2'h1
`define PDM_SRC_NONE 2'h2

// divisors
`define PDM_DIV_ONE 4'h1
`define PDM_DIV_MED 4'h8
`define PDM_DIV_W2 4'h2
`define PDM_DIV_W4 4'h4
`define PDM_DIV_W8 4'h8

// settling: shortest wait in states, one state per clock
`define PDM_SETTLE_BASE 8192
`define PDM_CNT_W 18

`endif

/* File: rtl/pdm_ctrl.v */
/*
 * power-down mode sequencer: mode state machine, settling wait, clock and
 * peripheral run selection, and its control registers on a plain port.
 * assumes halt_i is a one-cycle pulse from the cpu at a halt instruction,
 * request and enable inputs are levels synchronous to clk_i, and the reset pin
 * arrives already synchronised.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"

module pdm_ctrl #(
  parameter SETTLE_BASE = `PDM_SETTLE_BASE
) (
  input wire clk_i,
  input wire resetn_i,
  input wire [`PDM_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire reset_input_n_i,
  input wire halt_i,
  input wire int_mask_i,
  input wire [4:0] external_request_line_i,
  input wire [4:0] external_request_en_i,
  input wire [7:0] wakeup_pin_i,
  input wire [7:0] wakeup_pin_en_i,
  input wire [2:0] timer_req_i,
  input wire [2:0] timer_en_i,
  input wire other_req_i,
  output reg [`PDM_MODE_W-1:0] mode_o,
  output reg cpu_reset_o,
  output reg reset_exc_o,
  output reg int_exc_o,
  output reg osc_run_o,
  output reg cpu_run_o,
  output reg [1:0] cpu_clk_src_o,
  output reg [3:0] cpu_div_o,
  output reg periph_run_o,
  output reg timer_a_run_o,
  output reg timer_cg_run_o,
  output reg lcd_run_o,
  output reg port_hold_o,
  output reg port_hiz_o
);

  // ----------------------------------------------------------------
  // settling count
  // ----------------------------------------------------------------
  function [`PDM_CNT_W-1:0] settle_cycles;
    input [2:0] sel;
    reg [`PDM_CNT_W-1:0] base;
    begin
      base = SETTLE_BASE[`PDM_CNT_W-1:0];
      if (sel[2]) begin
        settle_cycles = base << 4;
      end else begin
        settle_cycles = base << sel[1:0];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_one_r;
  reg [7:0] ctrl_two_r;
  reg [7:0] timer_a_r;
  reg [`PDM_MODE_W-1:0] state_r;
  reg [`PDM_MODE_W-1:0] state_nxt;
  reg [`PDM_MODE_W-1:0] target_r;
  reg [`PDM_MODE_W-1:0] target_nxt;
  reg [`PDM_CNT_W-1:0] cnt_r;
  reg [`PDM_CNT_W-1:0] cnt_nxt;
  reg rexc_nxt;
  reg iexc_nxt;

  wire standby_select = ctrl_one_r[`PDM_BIT_STANDBY];
  wire low_speed_select = ctrl_one_r[`PDM_BIT_LOW_SPEED];
  wire [2:0] settle_sel = ctrl_one_r[`PDM_BIT_SETTLE_HI:`PDM_BIT_SETTLE_LO];
  wire medium_speed_select = ctrl_two_r[`PDM_BIT_MEDIUM];
  wire [1:0] subclock_div = ctrl_two_r[`PDM_BIT_SUBDIV_HI:0];
  wire watch_clock_select = timer_a_r[`PDM_BIT_WATCH_CLK];
  wire lcd_in_watch = timer_a_r[`PDM_BIT_LCD_WATCH];

  // ----------------------------------------------------------------
  // gated wake sources
  // ----------------------------------------------------------------
  wire [4:0] irq_ok = external_request_line_i & external_request_en_i & {5{~int_mask_i}};
  wire [7:0] wkp_ok = wakeup_pin_i & wakeup_pin_en_i & {8{~int_mask_i}};
  wire [2:0] tmr_ok = timer_req_i & timer_en_i & {3{~int_mask_i}};
  wire wkp_any = |wkp_ok;
  wire wake_standby = irq_ok[0] | irq_ok[1] | wkp_any;
  wire wake_watch = tmr_ok[0] | irq_ok[0] | wkp_any;
  wire wake_subsleep = (|tmr_ok) | (|irq_ok) | wkp_any;
  wire wake_sleep = wake_subsleep | (other_req_i & ~int_mask_i);
  wire [`PDM_MODE_W-1:0] active_target = medium_speed_select ?
    `PDM_M_ACT_MED : `PDM_M_ACT_HI;

  // ----------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    target_nxt = target_r;
    cnt_nxt = cnt_r;
    rexc_nxt = 1'b0;
    iexc_nxt = 1'b0;
    if (!reset_input_n_i) begin
      state_nxt = `PDM_M_RESET;
    end else begin
      case (state_r)
        `PDM_M_RESET: begin
          state_nxt = `PDM_M_ACT_HI;
          rexc_nxt = 1'b1;
        end
        `PDM_M_ACT_HI, `PDM_M_ACT_MED: begin
          if (halt_i) begin
            if (standby_select && watch_clock_select) begin
              state_nxt = `PDM_M_WATCH;
            end else if (standby_select && !low_speed_select) begin
              state_nxt = `PDM_M_STANDBY;
            end else if (!standby_select && !low_speed_select) begin
              state_nxt = `PDM_M_SLEEP;
            end
          end
        end
        `PDM_M_SUBACT: begin
          if (halt_i) begin
            if (standby_select && watch_clock_select) begin
              state_nxt = `PDM_M_WATCH;
            end else if (!standby_select && low_speed_select && watch_clock_select) begin
              state_nxt = `PDM_M_SUBSLEEP;
            end
          end
        end
        `PDM_M_SLEEP: begin
          if (wake_sleep) begin
            state_nxt = active_target;
            iexc_nxt = 1'b1;
          end
        end
        `PDM_M_STANDBY: begin
          if (wake_standby) begin
            state_nxt = `PDM_M_SETTLE;
            target_nxt = active_target;
            cnt_nxt = settle_cycles(settle_sel);
          end
        end
        `PDM_M_WATCH: begin
          if (wake_watch) begin
            if (low_speed_select) begin
              state_nxt = `PDM_M_SUBACT;
              iexc_nxt = 1'b1;
            end else begin
              state_nxt = `PDM_M_SETTLE;
              target_nxt = active_target;
              cnt_nxt = settle_cycles(settle_sel);
            end
          end
        end
        `PDM_M_SUBSLEEP: begin
          if (wake_subsleep) begin
            state_nxt = `PDM_M_SUBACT;
            iexc_nxt = 1'b1;
          end
        end
        `PDM_M_SETTLE: begin
          if (cnt_r <= {{(`PDM_CNT_W-1){1'b0}}, 1'b1}) begin
            state_nxt = target_r;
            iexc_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r - {{(`PDM_CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_nxt = `PDM_M_RESET;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= `PDM_M_RESET;
      target_r <= `PDM_M_ACT_HI;
      cnt_r <= {`PDM_CNT_W{1'b0}};
      reset_exc_o <= 1'b0;
      int_exc_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      target_r <= target_nxt;
      cnt_r <= cnt_nxt;
      reset_exc_o <= rexc_nxt;
      int_exc_o <= iexc_nxt;
    end
  end

  // ----------------------------------------------------------------
  // clock and run selection
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_o <= `PDM_M_RESET;
      cpu_reset_o <= 1'b1;
      osc_run_o <= 1'b1;
      cpu_run_o <= 1'b0;
      cpu_clk_src_o <= `PDM_SRC_SYS;
      cpu_div_o <= `PDM_DIV_ONE;
      periph_run_o <= 1'b0;
      timer_a_run_o <= 1'b0;
      timer_cg_run_o <= 1'b0;
      lcd_run_o <= 1'b0;
      port_hold_o <= 1'b0;
      port_hiz_o <= 1'b0;
    end else begin
      mode_o <= state_nxt;
      cpu_reset_o <= (state_nxt == `PDM_M_RESET);
      osc_run_o <= (state_nxt != `PDM_M_STANDBY) && (state_nxt != `PDM_M_WATCH) &&
        (state_nxt != `PDM_M_SUBSLEEP) && (state_nxt != `PDM_M_SUBACT);
      cpu_run_o <= (state_nxt == `PDM_M_ACT_HI) || (state_nxt == `PDM_M_ACT_MED) ||
        (state_nxt == `PDM_M_SUBACT);
      if (state_nxt == `PDM_M_SUBACT) begin
        cpu_clk_src_o <= `PDM_SRC_WATCH;
        cpu_div_o <= subclock_div[1] ? `PDM_DIV_W2 :
          (subclock_div[0] ? `PDM_DIV_W4 : `PDM_DIV_W8);
      end else if (state_nxt == `PDM_M_ACT_MED) begin
        cpu_clk_src_o <= `PDM_SRC_SYS;
        cpu_div_o <= `PDM_DIV_MED;
      end else if (state_nxt == `PDM_M_ACT_HI) begin
        cpu_clk_src_o <= `PDM_SRC_SYS;
        cpu_div_o <= `PDM_DIV_ONE;
      end else begin
        cpu_clk_src_o <= `PDM_SRC_NONE;
        cpu_div_o <= `PDM_DIV_ONE;
      end
      periph_run_o <= (state_nxt == `PDM_M_ACT_HI) || (state_nxt == `PDM_M_ACT_MED) ||
        (state_nxt == `PDM_M_SLEEP) || (state_nxt == `PDM_M_SUBACT);
      timer_a_run_o <= (state_nxt != `PDM_M_STANDBY) && (state_nxt != `PDM_M_RESET) &&
        (state_nxt != `PDM_M_SETTLE);
      timer_cg_run_o <= (state_nxt == `PDM_M_ACT_HI) || (state_nxt == `PDM_M_ACT_MED) ||
        (state_nxt == `PDM_M_SLEEP) || (state_nxt == `PDM_M_SUBACT) ||
        (state_nxt == `PDM_M_SUBSLEEP);
      lcd_run_o <= (state_nxt == `PDM_M_WATCH) ? lcd_in_watch :
        ((state_nxt != `PDM_M_STANDBY) && (state_nxt != `PDM_M_RESET) &&
        (state_nxt != `PDM_M_SETTLE));
      port_hold_o <= (state_nxt == `PDM_M_WATCH) || (state_nxt == `PDM_M_SUBSLEEP);
      port_hiz_o <= (state_nxt == `PDM_M_STANDBY);
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_one_r <= `PDM_CTRL_ONE_RST;
      ctrl_two_r <= `PDM_CTRL_TWO_RST;
      timer_a_r <= `PDM_TIMER_A_RST;
      rdata_o <= 8'h00;
    end else begin
      if (wr_i) begin
        case (addr_i)
          `PDM_OFS_CTRL_ONE: begin
            ctrl_one_r <= wdata_i | `PDM_CTRL_ONE_RSV;
          end
          `PDM_OFS_CTRL_TWO: begin
            // divider field frozen while the cpu runs from it
            if (state_r == `PDM_M_SUBACT) begin
              ctrl_two_r <= {3'h7, wdata_i[4:2], ctrl_two_r[1:0]};
            end else begin
              ctrl_two_r <= wdata_i | `PDM_CTRL_TWO_RSV;
            end
          end
          `PDM_OFS_TIMER_A: begin
            timer_a_r <= wdata_i;
          end
          default: begin
            ctrl_one_r <= ctrl_one_r;
          end
        endcase
      end
      if (rd_i) begin
        case (addr_i)
          `PDM_OFS_CTRL_ONE: rdata_o <= ctrl_one_r;
          `PDM_OFS_CTRL_TWO: rdata_o <= ctrl_two_r;
          `PDM_OFS_TIMER_A: rdata_o <= timer_a_r;
          `PDM_OFS_STATUS: rdata_o <= {4'h0, state_r};
          default: rdata_o <= 8'h00;
        endcase
      end else begin
        rdata_o <= 8'h00;
      end
    end
  end

endmodule // pdm_ctrl
`default_nettype wire

/* File: testbench/pdm_ctrl_monitor.sv */
/* port checker of the power-down mode sequencer.
   assumes it is bound into pdm_ctrl and sees the header constants. */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"
module pdm_ctrl_monitor #(
  parameter int SETTLE_BASE = 8192
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic reset_input_n_i,
  input wire logic int_mask_i,
  input wire logic [4:0] external_request_line_i,
  input wire logic [4:0] external_request_en_i,
  input wire logic [7:0] wakeup_pin_i,
  input wire logic [7:0] wakeup_pin_en_i,
  input wire logic [2:0] timer_req_i,
  input wire logic [2:0] timer_en_i,
  input wire logic [3:0] mode_o,
  input wire logic cpu_reset_o,
  input wire logic reset_exc_o,
  input wire logic int_exc_o,
  input wire logic osc_run_o,
  input wire logic cpu_run_o,
  input wire logic [1:0] cpu_clk_src_o,
  input wire logic [3:0] cpu_div_o,
  input wire logic periph_run_o,
  input wire logic timer_a_run_o,
  input wire logic timer_cg_run_o,
  input wire logic port_hold_o,
  input wire logic port_hiz_o
);
  // ----------------------------------------
  // helpers: divider shadow, settle length
  // ----------------------------------------
  logic [1:0] div_r;
  logic [17:0] cnt_r;
  logic wwake;
  assign wwake = (timer_req_i[0] & timer_en_i[0]) | (|(wakeup_pin_i & wakeup_pin_en_i))
    | (external_request_line_i[0] & external_request_en_i[0]);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= 2'h0;
      cnt_r <= 18'h00000;
    end else begin
      if (wr_i && addr_i == `PDM_OFS_CTRL_TWO && mode_o != `PDM_M_SUBACT) begin
        div_r <= wdata_i[1:0];
      end
      cnt_r <= (mode_o == `PDM_M_SETTLE) ? cnt_r + 18'h00001 : 18'h00000;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_PIN_RESET: assert property (!reset_input_n_i
    |=> mode_o == `PDM_M_RESET && cpu_reset_o)
    else $error("reset pin low did not enter reset");
  AST_RESET_EXIT: assert property (mode_o == `PDM_M_RESET && reset_input_n_i
    |=> mode_o == `PDM_M_ACT_HI && reset_exc_o) else $error("reset exit wrong");
  AST_MED_DIV: assert property (mode_o == `PDM_M_ACT_MED |-> cpu_div_o == `PDM_DIV_MED)
    else $error("medium divisor wrong");
  AST_SUB_DIV: assert property (mode_o == `PDM_M_SUBACT
    |-> cpu_clk_src_o == `PDM_SRC_WATCH
    && cpu_div_o == (div_r[1] ? `PDM_DIV_W2 : (div_r[0] ? `PDM_DIV_W4 : `PDM_DIV_W8)))
    else $error("subactive divisor wrong");
  AST_MASK_HOLD: assert property (mode_o inside {[`PDM_M_SLEEP:`PDM_M_SUBSLEEP]}
    && int_mask_i && reset_input_n_i |=> mode_o == $past(mode_o)) else $error("masked wake");
  AST_WATCH_STAY: assert property (mode_o == `PDM_M_WATCH && reset_input_n_i && !wwake
    |=> mode_o == `PDM_M_WATCH) else $error("watch left without cause");
  AST_WATCH_RUN: assert property (mode_o == `PDM_M_WATCH |-> timer_a_run_o
    && !timer_cg_run_o && !periph_run_o && port_hold_o) else $error("watch run set wrong");
  AST_SUBSLEEP_RUN: assert property (mode_o == `PDM_M_SUBSLEEP |-> timer_a_run_o
    && timer_cg_run_o && !periph_run_o && port_hold_o) else $error("subsleep run set wrong");
  AST_SUBSLEEP_WAKE: assert property (mode_o == `PDM_M_SUBSLEEP && reset_input_n_i
    && !int_mask_i && |(timer_req_i & timer_en_i) |=> mode_o == `PDM_M_SUBACT && int_exc_o)
    else $error("subsleep wake wrong");
  AST_SETTLE_EXIT: assert property ((mode_o == `PDM_M_SETTLE && reset_input_n_i)
    ##1 (mode_o != `PDM_M_SETTLE && mode_o != `PDM_M_RESET) |-> int_exc_o)
    else $error("no handling after settle");
  AST_SETTLE_MAX: assert property (cnt_r <= SETTLE_BASE * 16)
    else $error("settle wait too long");
  AST_SETTLE_MIN: assert property ((mode_o == `PDM_M_SETTLE && reset_input_n_i)
    ##1 (mode_o != `PDM_M_SETTLE && mode_o != `PDM_M_RESET) |-> cnt_r >= SETTLE_BASE)
    else $error("settle wait too short");
  AST_RESET_OSC: assert property (mode_o == `PDM_M_RESET |-> osc_run_o && !cpu_run_o)
    else $error("oscillator not restarted in reset");
  AST_STANDBY_RUN: assert property (mode_o == `PDM_M_STANDBY
    |-> !osc_run_o && !cpu_run_o && port_hiz_o) else $error("standby run set wrong");
endmodule // pdm_ctrl_monitor
bind pdm_ctrl pdm_ctrl_monitor #(.SETTLE_BASE(SETTLE_BASE)) mon_u (
  .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .reset_input_n_i(reset_input_n_i), .int_mask_i(int_mask_i),
  .external_request_line_i(external_request_line_i),
  .external_request_en_i(external_request_en_i), .wakeup_pin_i(wakeup_pin_i),
  .wakeup_pin_en_i(wakeup_pin_en_i), .timer_req_i(timer_req_i), .timer_en_i(timer_en_i),
  .mode_o(mode_o), .cpu_reset_o(cpu_reset_o), .reset_exc_o(reset_exc_o),
  .int_exc_o(int_exc_o), .osc_run_o(osc_run_o), .cpu_run_o(cpu_run_o),
  .cpu_clk_src_o(cpu_clk_src_o), .cpu_div_o(cpu_div_o), .periph_run_o(periph_run_o),
  .timer_a_run_o(timer_a_run_o), .timer_cg_run_o(timer_cg_run_o),
  .port_hold_o(port_hold_o), .port_hiz_o(port_hiz_o));
`default_nettype wire

/* File: testbench/pdm_cpu_model.sv */
/* cpu and reset source in front of the sequencer.
   assumes one-cycle halt requests from the bench. */
`timescale 1ns/1ps
`default_nettype none
module pdm_cpu_model #(
  parameter int HOLD = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic halt_req_i,
  input wire logic pin_req_i,
  output var logic halt_o,
  output logic reset_input_n_o
);
  logic [7:0] hold_r;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      halt_o <= 1'b0;
      hold_r <= 8'h00;
    end else begin
      halt_o <= halt_req_i;
      hold_r <= pin_req_i ? 8'(HOLD) : (hold_r != 8'h00 ? hold_r - 8'h01 : 8'h00);
    end
  end
  // pin kept low a while so the restarted oscillator can settle
  assign reset_input_n_o = !(pin_req_i || hold_r != 8'h00);
endmodule // pdm_cpu_model
`default_nettype wire

/* File: testbench/pdm_ctrl_bench.sv */
/* self-checking bench of the power-down mode sequencer.
   assumes a short settling base of 4 states, one cycle per state. */
`timescale 1ns/1ps
`default_nettype none
`include "pdm_consts.vh"
module pdm_ctrl_bench;
  logic clk_i, resetn_i, wr_i, rd_i, hreq, preq, int_mask_i, other_req_i;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, wakeup_pin_i, wakeup_pin_en_i;
  logic [4:0] external_request_line_i, external_request_en_i;
  logic [2:0] timer_req_i, timer_en_i;
  wire halt_i, reset_input_n_i, cpu_reset_o, reset_exc_o, int_exc_o, osc_run_o, cpu_run_o;
  wire periph_run_o, timer_a_run_o, timer_cg_run_o, lcd_run_o, port_hold_o, port_hiz_o;
  wire [7:0] rdata_o;
  wire [3:0] mode_o, cpu_div_o;
  wire [1:0] cpu_clk_src_o;
  int mismatches, n_tests, c, i, s;
  always #4 clk_i = ~clk_i;
  pdm_cpu_model cpu_u (.clk_i(clk_i), .resetn_i(resetn_i), .halt_req_i(hreq),
    .pin_req_i(preq), .halt_o(halt_i), .reset_input_n_o(reset_input_n_i));
  pdm_ctrl #(.SETTLE_BASE(4)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .reset_input_n_i(reset_input_n_i), .halt_i(halt_i), .int_mask_i(int_mask_i),
    .external_request_line_i(external_request_line_i),
    .external_request_en_i(external_request_en_i), .wakeup_pin_i(wakeup_pin_i),
    .wakeup_pin_en_i(wakeup_pin_en_i), .timer_req_i(timer_req_i), .timer_en_i(timer_en_i),
    .other_req_i(other_req_i), .mode_o(mode_o), .cpu_reset_o(cpu_reset_o),
    .reset_exc_o(reset_exc_o), .int_exc_o(int_exc_o), .osc_run_o(osc_run_o),
    .cpu_run_o(cpu_run_o), .cpu_clk_src_o(cpu_clk_src_o), .cpu_div_o(cpu_div_o),
    .periph_run_o(periph_run_o), .timer_a_run_o(timer_a_run_o),
    .timer_cg_run_o(timer_cg_run_o), .lcd_run_o(lcd_run_o), .port_hold_o(port_hold_o),
    .port_hiz_o(port_hiz_o));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task print_verdict;
    if (mismatches == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task cm(input logic [3:0] m);
    chk({4'h0, mode_o}, {4'h0, m});
  endtask
  task step;
    @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i) begin wr_i <= 1'b1; addr_i <= a; wdata_i <= d; end
    @(posedge clk_i) wr_i <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i) begin rd_i <= 1'b1; addr_i <= a; end
    @(posedge clk_i) rd_i <= 1'b0;
    #1;
    chk(rdata_o, e);
  endtask
  task halt;
    @(posedge clk_i) hreq <= 1'b1;
    @(posedge clk_i) hreq <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task waitm(input logic [3:0] m);
    for (int k = 0; k < 300 && mode_o !== m; k++) step();
    cm(m);
    if (mode_o !== m) print_verdict();
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    {clk_i, resetn_i, wr_i, rd_i, hreq, preq, int_mask_i, other_req_i} = 8'h00;
    {addr_i, wdata_i, wakeup_pin_i, external_request_line_i, timer_req_i} = 26'h0;
    {wakeup_pin_en_i, external_request_en_i, timer_en_i} = 16'hffff;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    step();
    cm(`PDM_M_ACT_HI);
    chk({6'h0, cpu_reset_o, reset_exc_o}, 8'h01);
    rd(`PDM_OFS_CTRL_ONE, `PDM_CTRL_ONE_RST);
    rd(`PDM_OFS_CTRL_TWO, `PDM_CTRL_TWO_RST);
    rd(`PDM_OFS_TIMER_A, `PDM_TIMER_A_RST);
    rd(`PDM_OFS_STATUS, 8'h00);
    for (s = 0; s < 5; s++) begin
      wr(`PDM_OFS_CTRL_ONE, {1'b1, s[2:0], 4'h0});
      halt();
      cm(`PDM_M_STANDBY);
      chk({6'h0, osc_run_o, port_hiz_o}, 8'h01);
      @(posedge clk_i) begin int_mask_i <= 1'b1; external_request_line_i <= 5'h01; end
      repeat (4) step();
      cm(`PDM_M_STANDBY);
      @(posedge clk_i) begin int_mask_i <= 1'b0; external_request_en_i <= 5'h1e; end
      repeat (2) step();
      cm(`PDM_M_STANDBY);
      @(posedge clk_i) external_request_en_i <= 5'h1f;
      c = 0;
      for (i = 0; i < 300; i++) begin
        step();
        if (mode_o === `PDM_M_SETTLE) c++;
        else if (c > 0) break;
      end
      chk(c[7:0], 8'(4 << (s > 3 ? 4 : s)));
      cm(`PDM_M_ACT_HI);
      chk({7'h0, int_exc_o}, 8'h01);
      @(posedge clk_i) external_request_line_i <= 5'h00;
    end
    wr(`PDM_OFS_TIMER_A, 8'h08);
    wr(`PDM_OFS_CTRL_TWO, 8'h04);
    wr(`PDM_OFS_CTRL_ONE, 8'h80);
    rd(`PDM_OFS_CTRL_ONE, 8'h87);
    halt();
    cm(`PDM_M_WATCH);
    chk({5'h0, cpu_run_o, lcd_run_o, timer_a_run_o}, 8'h01);
    @(posedge clk_i) timer_req_i <= 3'h1;
    waitm(`PDM_M_ACT_MED);
    chk({7'h0, int_exc_o}, 8'h01);
    chk({4'h0, cpu_div_o}, 8'h08);
    @(posedge clk_i) timer_req_i <= 3'h0;
    wr(`PDM_OFS_TIMER_A, 8'h00);
    halt();
    cm(`PDM_M_STANDBY);
    @(posedge clk_i) preq <= 1'b1;
    repeat (3) step();
    cm(`PDM_M_RESET);
    chk({6'h0, osc_run_o, cpu_reset_o}, 8'h03);
    @(posedge clk_i) preq <= 1'b0;
    waitm(`PDM_M_ACT_HI);
    chk({7'h0, reset_exc_o}, 8'h01);
    wr(`PDM_OFS_TIMER_A, 8'h09);
    wr(`PDM_OFS_CTRL_TWO, 8'h00);
    wr(`PDM_OFS_CTRL_ONE, 8'h88);
    halt();
    cm(`PDM_M_WATCH);
    chk({7'h0, lcd_run_o}, 8'h01);
    @(posedge clk_i) wakeup_pin_i <= 8'h08;
    step();
    cm(`PDM_M_SUBACT);
    chk({3'h0, int_exc_o, 2'h0, cpu_clk_src_o}, 8'h11);
    @(posedge clk_i) wakeup_pin_i <= 8'h00;
    wr(`PDM_OFS_CTRL_TWO, 8'h03);
    rd(`PDM_OFS_CTRL_TWO, 8'he0);
    step();
    chk({4'h0, cpu_div_o}, 8'h08);
    wr(`PDM_OFS_CTRL_ONE, 8'h08);
    halt();
    cm(`PDM_M_SUBSLEEP);
    @(posedge clk_i) timer_req_i <= 3'h2;
    step();
    cm(`PDM_M_SUBACT);
    @(posedge clk_i) timer_req_i <= 3'h0;
    wr(`PDM_OFS_CTRL_ONE, 8'h88);
    halt();
    cm(`PDM_M_WATCH);
    @(posedge clk_i) preq <= 1'b1;
    @(posedge clk_i) preq <= 1'b0;
    waitm(`PDM_M_ACT_HI);
    wr(`PDM_OFS_TIMER_A, 8'h00);
    wr(`PDM_OFS_CTRL_TWO, 8'h04);
    wr(`PDM_OFS_CTRL_ONE, 8'h00);
    halt();
    cm(`PDM_M_SLEEP);
    chk({6'h0, cpu_run_o, periph_run_o}, 8'h01);
    @(posedge clk_i) other_req_i <= 1'b1;
    step();
    cm(`PDM_M_ACT_MED);
    chk({7'h0, int_exc_o}, 8'h01);
    print_verdict();
  end
endmodule // pdm_ctrl_bench
`default_nettype wire
